//--- verilog/wdt_gpio_logical_unit.sv
// watchdog timer and two general-purpose ports behind an APB register file
`timescale 1ns/1ps
`default_nettype none
module wdt_gpio_logical_unit #(
	parameter int MS_CYCLES = wdt_gpio_pkg::MS_CYCLES
) (
	input  wire logic        I_MCLK,
	input  wire logic        I_RSTN,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [9:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output var  logic [31:0] O_PRDATA,
	output var  logic        O_PREADY,
	output var  logic        O_PSLVERR,
	input  wire logic [7:0]  I_PORT_FIVE_PINS,
	output var  logic [7:0]  O_PORT_FIVE_PINS,
	output var  logic [7:0]  O_PORT_FIVE_PINS_OE,
	input  wire logic [7:0]  I_PORT_SIX_PINS,
	output var  logic [7:0]  O_PORT_SIX_PINS,
	output var  logic [7:0]  O_PORT_SIX_PINS_OE,
	input  wire logic        I_KEYBOARD_CTRL_RESET_LINE,
	input  wire logic        I_MOUSE_IRQ,
	input  wire logic        I_KEYBOARD_IRQ,
	output var  logic        O_WATCHDOG_TIMEOUT_OUT_N,
	output var  logic        O_POWER_LED_OUT,
	output var  logic        O_KEYBOARD_RESET_PIN_N,
	output var  logic        O_SYSTEM_MGMT_INTERRUPT_N
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] merge_value(input logic [7:0] old,
		input logic [7:0] wdata, input logic [7:0] dir);
		merge_value = (wdata & ~dir) | (old & dir);
	endfunction

	function automatic logic [7:0] view_value(input logic [7:0] value,
		input logic [7:0] dir, input logic [7:0] inv, input logic [7:0] level);
		view_value = (value & ~dir) | ((level ^ inv) & dir);
	endfunction

	function automatic logic is_mapped(input logic [7:0] idx);
		case (idx)
			wdt_gpio_pkg::IDX_UNIT_ACTIVATE,
			wdt_gpio_pkg::IDX_BASE_ADDR_HIGH,
			wdt_gpio_pkg::IDX_BASE_ADDR_LOW,
			wdt_gpio_pkg::IDX_P5_DIRECTION,
			wdt_gpio_pkg::IDX_P5_VALUE,
			wdt_gpio_pkg::IDX_P5_INVERT,
			wdt_gpio_pkg::IDX_P5_EDGE_EVENTS,
			wdt_gpio_pkg::IDX_P6_DIRECTION,
			wdt_gpio_pkg::IDX_P6_VALUE,
			wdt_gpio_pkg::IDX_P6_INVERT,
			wdt_gpio_pkg::IDX_P6_EDGE_EVENTS,
			wdt_gpio_pkg::IDX_WATCHDOG_MODE,
			wdt_gpio_pkg::IDX_WATCHDOG_COUNT,
			wdt_gpio_pkg::IDX_WATCHDOG_CONTROL: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	gpio_port_if p5_if ();
	gpio_port_if p6_if ();

	logic [7:0] act_q;
	logic [7:0] base_hi_q;
	logic [7:0] base_lo_q;
	logic [7:0] p5_dir_q;
	logic [7:0] p5_val_q;
	logic [7:0] p5_inv_q;
	logic [7:0] p5_evt_q;
	logic [7:0] p6_dir_q;
	logic [7:0] p6_val_q;
	logic [7:0] p6_inv_q;
	logic [7:0] p6_evt_q;
	logic [7:0] mode_q;
	logic [7:0] count_q;
	logic [7:0] reload_q;
	logic [7:0] ctl_q;
	logic       status_q;
	logic [7:0] keyboard_reset_pin_n_cnt_q;
	wdt_gpio_pkg::wd_state_t state_q;

	logic [7:0] idx;
	logic       access;
	logic       done;
	logic       wr_en;
	logic       rd_done;
	logic [7:0] wbyte;
	logic [7:0] rd_mux;

	logic [2:0] in_sync1_q;
	logic [2:0] in_sync2_q;
	logic [2:0] in_prev_q;
	logic       kbc_rise;
	logic       mouse_rise;
	logic       kbd_rise;

	logic       tick;
	logic       restart;
	logic       sw_load;
	logic       hw_reload;
	logic       zero_evt;
	logic       timeout_evt;
	logic       status_clr;

	// ----------------------------------------------------------------
	// apb slave: one wait cycle, answer on the second access cycle
	// ----------------------------------------------------------------
	assign idx     = I_PADDR[9:2];
	assign access  = I_PSEL & I_PENABLE;
	assign done    = access & O_PREADY;
	assign wr_en   = done & I_PWRITE & is_mapped(idx);
	assign rd_done = done & ~I_PWRITE;
	assign wbyte   = I_PWDATA[7:0];

	always_comb begin
		case (idx)
			wdt_gpio_pkg::IDX_UNIT_ACTIVATE:    rd_mux = act_q;
			wdt_gpio_pkg::IDX_BASE_ADDR_HIGH:   rd_mux = base_hi_q;
			wdt_gpio_pkg::IDX_BASE_ADDR_LOW:    rd_mux = base_lo_q;
			wdt_gpio_pkg::IDX_P5_DIRECTION:     rd_mux = p5_dir_q;
			wdt_gpio_pkg::IDX_P5_VALUE:
				rd_mux = view_value(p5_val_q, p5_dir_q, p5_inv_q, p5_if.level);
			wdt_gpio_pkg::IDX_P5_INVERT:        rd_mux = p5_inv_q;
			wdt_gpio_pkg::IDX_P5_EDGE_EVENTS:   rd_mux = p5_evt_q;
			wdt_gpio_pkg::IDX_P6_DIRECTION:     rd_mux = p6_dir_q;
			wdt_gpio_pkg::IDX_P6_VALUE:
				rd_mux = view_value(p6_val_q, p6_dir_q, p6_inv_q, p6_if.level);
			wdt_gpio_pkg::IDX_P6_INVERT:        rd_mux = p6_inv_q;
			wdt_gpio_pkg::IDX_P6_EDGE_EVENTS:   rd_mux = p6_evt_q;
			wdt_gpio_pkg::IDX_WATCHDOG_MODE:    rd_mux = mode_q;
			wdt_gpio_pkg::IDX_WATCHDOG_COUNT:   rd_mux = count_q;
			wdt_gpio_pkg::IDX_WATCHDOG_CONTROL: rd_mux = {ctl_q[7:6], 1'b0, status_q,
				ctl_q[3:0]};
			default:                            rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
			O_PRDATA  <= 32'h0000_0000;
		end else begin
			O_PREADY  <= access & ~O_PREADY;
			O_PSLVERR <= access & ~O_PREADY & ~is_mapped(idx);
			if (access && !O_PREADY && !I_PWRITE) begin
				O_PRDATA <= {24'h000000, rd_mux};
			end
		end
	end

	// ----------------------------------------------------------------
	// activation and base address
	// ----------------------------------------------------------------
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			act_q     <= wdt_gpio_pkg::RST_UNIT_ACTIVATE;
			base_hi_q <= wdt_gpio_pkg::RST_ZERO;
			base_lo_q <= wdt_gpio_pkg::RST_ZERO;
		end else if (wr_en) begin
			case (idx)
				wdt_gpio_pkg::IDX_UNIT_ACTIVATE:  act_q     <= {5'b00000, wbyte[2:0]};
				wdt_gpio_pkg::IDX_BASE_ADDR_HIGH: base_hi_q <= wbyte;
				wdt_gpio_pkg::IDX_BASE_ADDR_LOW:
					base_lo_q <= wbyte & wdt_gpio_pkg::BASE_LOW_MASK;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// port registers
	// ----------------------------------------------------------------
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			p5_dir_q <= wdt_gpio_pkg::RST_DIRECTION;
			p6_dir_q <= wdt_gpio_pkg::RST_DIRECTION;
			p5_val_q <= wdt_gpio_pkg::RST_P5_VALUE;
			p6_val_q <= wdt_gpio_pkg::RST_P6_VALUE;
			p5_inv_q <= wdt_gpio_pkg::RST_ZERO;
			p6_inv_q <= wdt_gpio_pkg::RST_ZERO;
		end else if (wr_en) begin
			case (idx)
				wdt_gpio_pkg::IDX_P5_DIRECTION: p5_dir_q <= wbyte;
				wdt_gpio_pkg::IDX_P6_DIRECTION: p6_dir_q <= wbyte;
				wdt_gpio_pkg::IDX_P5_VALUE: p5_val_q <= merge_value(p5_val_q, wbyte, p5_dir_q);
				wdt_gpio_pkg::IDX_P6_VALUE: p6_val_q <= merge_value(p6_val_q, wbyte, p6_dir_q);
				wdt_gpio_pkg::IDX_P5_INVERT:    p5_inv_q <= wbyte;
				wdt_gpio_pkg::IDX_P6_INVERT:    p6_inv_q <= wbyte;
				default: ;
			endcase
		end
	end

	// cleared bits are those returned by the read, so a new edge is never lost
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			p5_evt_q <= wdt_gpio_pkg::RST_ZERO;
			p6_evt_q <= wdt_gpio_pkg::RST_ZERO;
		end else begin
			p5_evt_q <= (p5_evt_q & ~((rd_done && idx == wdt_gpio_pkg::IDX_P5_EDGE_EVENTS) ?
				O_PRDATA[7:0] : 8'h00)) | p5_if.edge_seen;
			p6_evt_q <= (p6_evt_q & ~((rd_done && idx == wdt_gpio_pkg::IDX_P6_EDGE_EVENTS) ?
				O_PRDATA[7:0] : 8'h00)) | p6_if.edge_seen;
		end
	end

	assign p5_if.active = act_q[wdt_gpio_pkg::ACT_P5_BIT];
	assign p5_if.dir    = p5_dir_q;
	assign p5_if.inv    = p5_inv_q;
	assign p5_if.value  = p5_val_q;
	assign p6_if.active = act_q[wdt_gpio_pkg::ACT_P6_BIT];
	assign p6_if.dir    = p6_dir_q;
	assign p6_if.inv    = p6_inv_q;
	assign p6_if.value  = p6_val_q;

	gpio_port u_port_five (
		.i_clk_pins (I_PORT_FIVE_PINS),
		.i_clk      (I_MCLK),
		.i_rst_n    (I_RSTN),
		.o_pins     (O_PORT_FIVE_PINS),
		.o_oe       (O_PORT_FIVE_PINS_OE),
		.port       (p5_if.pins)
	);

	gpio_port u_port_six (
		.i_clk_pins (I_PORT_SIX_PINS),
		.i_clk      (I_MCLK),
		.i_rst_n    (I_RSTN),
		.o_pins     (O_PORT_SIX_PINS),
		.o_oe       (O_PORT_SIX_PINS_OE),
		.port       (p6_if.pins)
	);

	// ----------------------------------------------------------------
	// external event inputs: synchronise, then rising edges
	// ----------------------------------------------------------------
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			in_sync1_q <= 3'b000;
			in_sync2_q <= 3'b000;
			in_prev_q  <= 3'b000;
		end else begin
			in_sync1_q <= {I_KEYBOARD_IRQ, I_MOUSE_IRQ, I_KEYBOARD_CTRL_RESET_LINE};
			in_sync2_q <= in_sync1_q;
			in_prev_q  <= in_sync2_q;
		end
	end

	assign kbc_rise   = in_sync2_q[0] & ~in_prev_q[0];
	assign mouse_rise = in_sync2_q[1] & ~in_prev_q[1];
	assign kbd_rise   = in_sync2_q[2] & ~in_prev_q[2];

	// ----------------------------------------------------------------
	// watchdog mode and control
	// ----------------------------------------------------------------
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			mode_q <= wdt_gpio_pkg::RST_ZERO;
			ctl_q  <= wdt_gpio_pkg::RST_ZERO;
		end else if (wr_en) begin
			case (idx)
				wdt_gpio_pkg::IDX_WATCHDOG_MODE: mode_q <= wbyte & wdt_gpio_pkg::MODE_MASK;
				wdt_gpio_pkg::IDX_WATCHDOG_CONTROL:
					ctl_q <= {wbyte[7:6], 2'b00, wbyte[3:0]};
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// watchdog counter
	// ----------------------------------------------------------------
	assign sw_load   = wr_en && idx == wdt_gpio_pkg::IDX_WATCHDOG_COUNT;
	assign hw_reload = (reload_q != 8'h00) &&
		((mouse_rise && ctl_q[wdt_gpio_pkg::CTL_MOUSE_BIT]) ||
		 (kbd_rise && ctl_q[wdt_gpio_pkg::CTL_KBD_BIT]));
	assign restart   = sw_load | hw_reload;
	assign zero_evt  = (state_q == wdt_gpio_pkg::WD_RUN) && tick && !restart &&
		count_q == 8'h01;
	assign timeout_evt = zero_evt ||
		(kbc_rise && mode_q[wdt_gpio_pkg::MODE_KBC_EDGE_BIT]) ||
		(wr_en && idx == wdt_gpio_pkg::IDX_WATCHDOG_CONTROL &&
		 wbyte[wdt_gpio_pkg::CTL_FORCE_BIT]);
	assign status_clr = wr_en && idx == wdt_gpio_pkg::IDX_WATCHDOG_CONTROL &&
		!wbyte[wdt_gpio_pkg::CTL_STATUS_BIT];

	wdt_tick_gen #(
		.MS_CYCLES (MS_CYCLES)
	) u_tick (
		.i_clk     (I_MCLK),
		.i_rst_n   (I_RSTN),
		.i_restart (restart),
		.i_fast    (mode_q[wdt_gpio_pkg::MODE_FAST_BIT]),
		.i_minute  (mode_q[wdt_gpio_pkg::MODE_MINUTE_BIT]),
		.o_tick    (tick)
	);

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			state_q  <= wdt_gpio_pkg::WD_STOP;
			count_q  <= wdt_gpio_pkg::RST_ZERO;
			reload_q <= wdt_gpio_pkg::RST_ZERO;
		end else if (sw_load) begin
			count_q <= wbyte;
			if (wbyte != 8'h00) begin
				reload_q <= wbyte;
				state_q  <= wdt_gpio_pkg::WD_RUN;
			end else begin
				state_q  <= wdt_gpio_pkg::WD_STOP;
			end
		end else if (hw_reload) begin
			count_q <= reload_q;
			state_q <= wdt_gpio_pkg::WD_RUN;
		end else begin
			case (state_q)
				wdt_gpio_pkg::WD_RUN: begin
					if (tick) begin
						count_q <= count_q - 8'h01;
						if (count_q == 8'h01) begin
							state_q <= wdt_gpio_pkg::WD_STOP;
						end
					end
				end
				wdt_gpio_pkg::WD_STOP: state_q <= wdt_gpio_pkg::WD_STOP;
				default:               state_q <= wdt_gpio_pkg::WD_STOP;
			endcase
		end
	end

	// a time-out arriving with a clearing write still sets the status
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			status_q <= 1'b0;
		end else begin
			status_q <= timeout_evt | (status_q & ~status_clr);
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			keyboard_reset_pin_n_cnt_q <= 8'h00;
		end else if (timeout_evt && mode_q[wdt_gpio_pkg::MODE_KEYBOARD_RESET_PIN_N_BIT] &&
			act_q[wdt_gpio_pkg::ACT_WATCHDOG_BIT]) begin
			keyboard_reset_pin_n_cnt_q <= wdt_gpio_pkg::KEYBOARD_RESET_PIN_N_PULSE_CYCLES;
		end else if (keyboard_reset_pin_n_cnt_q != 8'h00) begin
			keyboard_reset_pin_n_cnt_q <= keyboard_reset_pin_n_cnt_q - 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// watchdog outputs
	// ----------------------------------------------------------------
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_WATCHDOG_TIMEOUT_OUT_N  <= 1'b1;
			O_POWER_LED_OUT           <= 1'b0;
			O_KEYBOARD_RESET_PIN_N    <= 1'b1;
			O_SYSTEM_MGMT_INTERRUPT_N <= 1'b1;
		end else begin
			O_WATCHDOG_TIMEOUT_OUT_N  <= ~(status_q &
				act_q[wdt_gpio_pkg::ACT_WATCHDOG_BIT]);
			O_POWER_LED_OUT           <= act_q[wdt_gpio_pkg::ACT_WATCHDOG_BIT];
			O_KEYBOARD_RESET_PIN_N    <= (keyboard_reset_pin_n_cnt_q == 8'h00);
			O_SYSTEM_MGMT_INTERRUPT_N <= ~(status_q &
				(ctl_q[3:0] == wdt_gpio_pkg::IRQ_SEL_SMI));
		end
	end

endmodule
`default_nettype wire

//--- verilog/wdt_gpio_pkg.sv
// shared constants and types for the watchdog and general-purpose port unit
package wdt_gpio_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_UNIT_ACTIVATE    = 8'h30;
	localparam logic [7:0] IDX_BASE_ADDR_HIGH   = 8'h60;
	localparam logic [7:0] IDX_BASE_ADDR_LOW    = 8'h61;
	localparam logic [7:0] IDX_P5_DIRECTION     = 8'hE0;
	localparam logic [7:0] IDX_P5_VALUE         = 8'hE1;
	localparam logic [7:0] IDX_P5_INVERT        = 8'hE2;
	localparam logic [7:0] IDX_P5_EDGE_EVENTS   = 8'hE3;
	localparam logic [7:0] IDX_P6_DIRECTION     = 8'hE4;
	localparam logic [7:0] IDX_P6_VALUE         = 8'hE5;
	localparam logic [7:0] IDX_P6_INVERT        = 8'hE6;
	localparam logic [7:0] IDX_P6_EDGE_EVENTS   = 8'hE7;
	localparam logic [7:0] IDX_WATCHDOG_MODE    = 8'hF5;
	localparam logic [7:0] IDX_WATCHDOG_COUNT   = 8'hF6;
	localparam logic [7:0] IDX_WATCHDOG_CONTROL = 8'hF7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_UNIT_ACTIVATE = 8'h02;
	localparam logic [7:0] RST_ZERO          = 8'h00;
	localparam logic [7:0] RST_DIRECTION     = 8'hFF;
	localparam logic [7:0] RST_P5_VALUE      = 8'h00;
	localparam logic [7:0] RST_P6_VALUE      = 8'h1F;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ACT_WATCHDOG_BIT = 0;
	localparam int ACT_P5_BIT       = 1;
	localparam int ACT_P6_BIT       = 2;
	localparam int MODE_FAST_BIT    = 4;
	localparam int MODE_MINUTE_BIT  = 3;
	localparam int MODE_KBC_EDGE_BIT = 2;
	localparam int MODE_KEYBOARD_RESET_PIN_N_BIT   = 1;
	localparam logic [7:0] MODE_MASK = 8'h1E;
	localparam int CTL_MOUSE_BIT    = 7;
	localparam int CTL_KBD_BIT      = 6;
	localparam int CTL_FORCE_BIT    = 5;
	localparam int CTL_STATUS_BIT   = 4;
	localparam logic [3:0] IRQ_SEL_SMI = 4'h2;
	localparam logic [7:0] BASE_LOW_MASK = 8'hFC;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 50;
	localparam int MS_NS           = 1000000;
	localparam int MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
	localparam logic [15:0] MS_PER_SEC  = 16'h03E8;
	localparam logic [15:0] SEC_PER_MIN = 16'h003C;
	localparam logic [15:0] MS_PER_MIN  = 16'hEA60;
	localparam logic [15:0] UNIT_ONE    = 16'h0001;
	localparam int KEYBOARD_RESET_PIN_N_PULSE_NS  = 1000;
	localparam logic [7:0] KEYBOARD_RESET_PIN_N_PULSE_CYCLES =
		8'((KEYBOARD_RESET_PIN_N_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		WD_STOP = 2'b01,
		WD_RUN  = 2'b10
	} wd_state_t;

endpackage

//--- verilog/gpio_port_if.sv
// bundle between the register file and one general-purpose port
`timescale 1ns/1ps
`default_nettype none
interface gpio_port_if;
	logic       active;
	logic [7:0] dir;
	logic [7:0] inv;
	logic [7:0] value;
	logic [7:0] level;
	logic [7:0] edge_seen;

	modport regs (output active, output dir, output inv, output value,
		input level, input edge_seen);
	modport pins (input active, input dir, input inv, input value,
		output level, output edge_seen);
endinterface
`default_nettype wire

//--- verilog/wdt_tick_gen.sv
// watchdog prescaler: one-cycle tick per counting unit
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_gen #(
	parameter int MS_CYCLES = wdt_gpio_pkg::MS_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_restart,
	input  wire logic i_fast,
	input  wire logic i_minute,
	output var  logic o_tick
);
	logic [15:0] cyc_q;
	logic [15:0] ms_q;
	logic [15:0] ms_limit;
	logic        ms_tick;

	// ms per unit: 1 ms, 60 ms, 1 s or 1 min
	always_comb begin
		if (i_fast) begin
			ms_limit = i_minute ? wdt_gpio_pkg::SEC_PER_MIN : wdt_gpio_pkg::UNIT_ONE;
		end else begin
			ms_limit = i_minute ? wdt_gpio_pkg::MS_PER_MIN : wdt_gpio_pkg::MS_PER_SEC;
		end
	end

	assign ms_tick = (cyc_q == 16'(MS_CYCLES - 1));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cyc_q <= 16'h0000;
		end else if (i_restart || ms_tick) begin
			cyc_q <= 16'h0000;
		end else begin
			cyc_q <= cyc_q + 16'h0001;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ms_q   <= 16'h0000;
			o_tick <= 1'b0;
		end else if (i_restart) begin
			ms_q   <= 16'h0000;
			o_tick <= 1'b0;
		end else if (ms_tick) begin
			o_tick <= (ms_q >= ms_limit - 16'h0001);
			ms_q   <= (ms_q >= ms_limit - 16'h0001) ? 16'h0000 : ms_q + 16'h0001;
		end else begin
			o_tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- verilog/gpio_port.sv
// one 8-bit port: pin synchroniser, edge detector and pin drivers
`timescale 1ns/1ps
`default_nettype none
module gpio_port (
	input  wire logic [7:0] i_clk_pins,
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	output var  logic [7:0] o_pins,
	output var  logic [7:0] o_oe,
	gpio_port_if.pins       port
);
	logic [7:0] sync1_q;
	logic [7:0] sync2_q;
	logic [7:0] prev_q;
	logic [2:0] fill_q;

	// no events until the pipeline holds real pin levels, so no false edge after reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fill_q <= 3'b000;
		end else begin
			fill_q <= {fill_q[1:0], 1'b1};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
			prev_q  <= 8'h00;
		end else begin
			sync1_q <= i_clk_pins;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	assign port.level     = sync2_q;
	assign port.edge_seen = (port.active && fill_q[2]) ? (sync2_q ^ prev_q) : 8'h00;

	// while the port is active, a zero direction bit drives the pin with the data bit through the inverter
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pins <= 8'h00;
			o_oe   <= 8'h00;
		end else begin
			o_pins <= port.value ^ port.inv;
			o_oe   <= port.active ? ~port.dir : 8'h00;
		end
	end
endmodule
`default_nettype wire

//--- bench/wdt_gpio_asserts.sv
// port-level checker for the watchdog and port unit
`timescale 1ns/1ps
`default_nettype none
module wdt_gpio_asserts (
	input wire logic        I_MCLK,
	input wire logic        I_RSTN,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [9:0]  I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [31:0] O_PRDATA,
	input wire logic        O_PREADY,
	input wire logic        O_PSLVERR,
	input wire logic        O_WATCHDOG_TIMEOUT_OUT_N,
	input wire logic        O_POWER_LED_OUT,
	input wire logic        O_KEYBOARD_RESET_PIN_N,
	input wire logic        O_SYSTEM_MGMT_INTERRUPT_N
);
	// ----------------------------------------------------------------
	// helpers: reset pulse length and status clearing writes
	// ----------------------------------------------------------------
	logic [7:0] low_cnt_q;
	wire clr_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR[9:2] == 8'hF7
		&& !I_PWDATA[4];
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN)
			low_cnt_q <= 8'h00;
		else if (!O_KEYBOARD_RESET_PIN_N)
			low_cnt_q <= low_cnt_q + 8'h01;
		else
			low_cnt_q <= 8'h00;
	end
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RSTN);
	sequence setup_s;
		I_PSEL && !I_PENABLE ##1 I_PSEL && I_PENABLE;
	endsequence
	ready_after_setup_a: assert property (setup_s |=> O_PREADY)
		else $error("ready missing after access");
	ready_one_cycle_a: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	err_with_ready_a: assert property (O_PSLVERR |-> O_PREADY)
		else $error("error without ready");
	rdata_upper_zero_a: assert property (O_PREADY |-> O_PRDATA[31:8] == 24'h000000)
		else $error("read data upper bits set");
	timeout_gated_a: assert property (!O_WATCHDOG_TIMEOUT_OUT_N |-> O_POWER_LED_OUT)
		else $error("timeout output while inactive");
	keyboard_reset_pin_n_pulse_len_a: assert property ($rose(O_KEYBOARD_RESET_PIN_N) |-> low_cnt_q == 8'h14)
		else $error("keyboard reset pulse length wrong");
	smi_hold_a: assert property ($rose(O_SYSTEM_MGMT_INTERRUPT_N) |->
		$past(clr_wr) || $past(clr_wr, 2)) else $error("smi released without clear");
	timeout_hold_a: assert property ($rose(O_WATCHDOG_TIMEOUT_OUT_N) |->
		$past(clr_wr) || $past(clr_wr, 2) || !O_POWER_LED_OUT) else $error("timeout released early");
endmodule

bind wdt_gpio_logical_unit wdt_gpio_asserts chk_u (.I_MCLK, .I_RSTN, .I_PSEL, .I_PENABLE,
	.I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_WATCHDOG_TIMEOUT_OUT_N,
	.O_POWER_LED_OUT, .O_KEYBOARD_RESET_PIN_N, .O_SYSTEM_MGMT_INTERRUPT_N);
`default_nettype wire

//--- bench/tb.sv
// self-checking testbench for the watchdog and port unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rstn, psel, pen, pwr, mirq, kirq, p20, pready, pslverr;
	logic watchdog_timeout_out_n_n, led, keyboard_reset_pin_n_n, smi_n;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] p5i, p6i, p5o, p5oe, p6o, p6oe, r;
	logic e;
	int mismatches, n_compared, n;
	localparam logic [7:0] RIDX [14] = '{8'h30, 8'h60, 8'h61, 8'hE0, 8'hE1, 8'hE2, 8'hE3,
		8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hF5, 8'hF6, 8'hF7};
	localparam logic [7:0] RVAL [14] = '{8'h02, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
		8'hFF, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	wdt_gpio_logical_unit #(.MS_CYCLES(4)) dut_u (.I_MCLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_PORT_FIVE_PINS(p5i), .O_PORT_FIVE_PINS(p5o),
		.O_PORT_FIVE_PINS_OE(p5oe), .I_PORT_SIX_PINS(p6i), .O_PORT_SIX_PINS(p6o),
		.O_PORT_SIX_PINS_OE(p6oe), .I_KEYBOARD_CTRL_RESET_LINE(p20), .I_MOUSE_IRQ(mirq),
		.I_KEYBOARD_IRQ(kirq), .O_WATCHDOG_TIMEOUT_OUT_N(watchdog_timeout_out_n_n), .O_POWER_LED_OUT(led),
		.O_KEYBOARD_RESET_PIN_N(keyboard_reset_pin_n_n), .O_SYSTEM_MGMT_INTERRUPT_N(smi_n));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		{psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, idx, 2'b00, 24'h000000, wd};
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 40);
		r = prdata[7:0];
		e = pslverr;
		{psel, pen} <= 2'b00;
		if (k >= 40)
			mismatches++;
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(r, exp);
	endtask
	task automatic kick(input logic m);
		{mirq, kirq} <= {m, !m};
		repeat (3) @(posedge clk);
		{mirq, kirq} <= 2'b00;
		repeat (4) @(posedge clk);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 14; i++)
			rdc(RIDX[i], RVAL[i]);
		chk({p6o, p5o, p5oe, p6oe}, 32'h1F000000);
		chk(led, 1'b0);
		apb(1'b1, 8'h40, 8'h5A);
		rdc(8'h40, 8'h00);
		chk(e, 1'b1);
		apb(1'b1, 8'h61, 8'hFF);
		rdc(8'h61, 8'hFC);
	endtask
	task automatic t_gpio;
		p5i <= 8'h06;
		apb(1'b1, 8'hE0, 8'h0F);
		apb(1'b1, 8'hE1, 8'hA5);
		apb(1'b1, 8'hE2, 8'h31);
		repeat (2) @(posedge clk);
		chk({p5oe, p5o}, 16'hF091);
		rdc(8'hE1, 8'hA7);
		rdc(8'hE3, 8'h06);
		rdc(8'hE3, 8'h00);
		{p5i, p6i} <= 16'h041E;
		repeat (8) @(posedge clk);
		rdc(8'hE3, 8'h02);
		rdc(8'hE7, 8'h00);
		apb(1'b1, 8'h30, 8'h04);
		apb(1'b1, 8'hE4, 8'hF0);
		repeat (2) @(posedge clk);
		chk({p6oe, p5oe, p6o}, 24'h0F001F);
	endtask
	task automatic t_timer;
		apb(1'b1, 8'h30, 8'h03);
		apb(1'b1, 8'hF7, 8'h02);
		apb(1'b1, 8'hF5, 8'h1A);
		rdc(8'hF5, 8'h1A);
		apb(1'b1, 8'hF6, 8'h03);
		n = 0;
		while (watchdog_timeout_out_n_n !== 1'b0 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		chk(n >= 718 && n <= 726, 1'b1);
		@(posedge clk);
		chk({keyboard_reset_pin_n_n, smi_n}, 2'b00);
		chk(led, 1'b1);
		rdc(8'hF7, 8'h12);
		repeat (800) @(posedge clk);
		rdc(8'hF6, 8'h00);
		chk(watchdog_timeout_out_n_n, 1'b0);
		apb(1'b1, 8'hF7, 8'h02);
		repeat (2) @(posedge clk);
		chk({watchdog_timeout_out_n_n, smi_n}, 2'b11);
	endtask
	task automatic t_reload;
		apb(1'b1, 8'hF7, 8'hC2);
		apb(1'b1, 8'hF5, 8'h18);
		apb(1'b1, 8'hF6, 8'h02);
		repeat (300) @(posedge clk);
		kick(1'b1);
		rdc(8'hF6, 8'h02);
		repeat (300) @(posedge clk);
		kick(1'b0);
		rdc(8'hF6, 8'h02);
		apb(1'b1, 8'hF7, 8'h02);
		repeat (300) @(posedge clk);
		kick(1'b1);
		kick(1'b0);
		rdc(8'hF6, 8'h01);
		apb(1'b1, 8'hF6, 8'h00);
		repeat (800) @(posedge clk);
		chk(watchdog_timeout_out_n_n, 1'b1);
		apb(1'b1, 8'hF5, 8'h04);
		p20 <= 1'b1;
		repeat (6) @(posedge clk);
		chk(watchdog_timeout_out_n_n, 1'b0);
		p20 <= 1'b0;
		apb(1'b1, 8'hF7, 8'h00);
		apb(1'b1, 8'hF5, 8'h00);
		p20 <= 1'b1;
		repeat (6) @(posedge clk);
		chk(watchdog_timeout_out_n_n, 1'b1);
		apb(1'b1, 8'hF7, 8'h20);
		repeat (3) @(posedge clk);
		chk({watchdog_timeout_out_n_n, smi_n}, 2'b01);
		rdc(8'hF7, 8'h10);
		apb(1'b1, 8'hF7, 8'h02);
		apb(1'b1, 8'hF5, 8'h10);
		apb(1'b1, 8'hF6, 8'h05);
		n = 0;
		while (watchdog_timeout_out_n_n !== 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(n >= 20 && n <= 24, 1'b1);
		chk(smi_n, 1'b0);
	endtask
	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#3000000;
		mismatches++;
		tally_and_finish;
	end
	initial begin
		{rstn, psel, pen, pwr, mirq, kirq, p20, paddr, pwdata} = '0;
		{p5i, p6i, mismatches, n_compared} = {8'h00, 8'h1F, 64'h0};
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_gpio;
		t_timer;
		t_reload;
		tally_and_finish;
	end
endmodule
`default_nettype wire
